// >>> rtl/svw_params.svh
// Timing constants and encodings for the supervisor watchdog
`ifndef SVW_PARAMS_SVH
`define SVW_PARAMS_SVH
`define SVW_CLK_MHZ          20
`define SVW_T_RST_MS         200
`define SVW_T_WD_OPEN_MS     1600
`define SVW_T_WD_PULLUP_MS   200
`define SVW_T_CAP_STD_MIN_US 704
`define SVW_T_CAP_STD_MAX_US 3230000
`define SVW_T_CAP_EXT_MIN_US 62740
`define SVW_T_CAP_EXT_MAX_US 77450000
`define SVW_MS_CYCLES(ms)    ((ms) * `SVW_CLK_MHZ * 1000)
`define SVW_US_CYCLES(us)    ((us) * `SVW_CLK_MHZ)
`define SVW_CNT_W            32
`define SVW_CNT_ZERO         32'h0000_0000
`define SVW_CNT_ONE          32'h0000_0001
`endif

// >>> rtl/svw_pkg.sv
// Types shared by the supervisor watchdog
package svw_pkg;
    // Timeout source chosen by the timing-configuration input
    typedef enum logic [1:0] {
        SVW_CFG_CAP    = 2'b00,
        SVW_CFG_PULLUP = 2'b01,
        SVW_CFG_OPEN   = 2'b10
    } svw_cfg_src_type;

    // Watchdog configuration carried as one group
    typedef struct packed {
        logic            timeout_select;
        svw_cfg_src_type timeout_cfg_in;
        logic [31:0]     cap_cycles;
    } svw_wd_cfg_type;

    // Supply monitor indications
    typedef struct packed {
        logic lockout;
        logic undervoltage;
        logic supply_good;
    } svw_supply_type;

    // Supervisor state
    typedef enum logic [1:0] {
        SVW_ST_HOLD = 2'b00,
        SVW_ST_RUN  = 2'b01,
        SVW_ST_WDO  = 2'b10
    } svw_state_type;
endpackage

// >>> rtl/svw_top.sv
// Reset supervisor with watchdog timer
//
// Contract
// - Reset output asserts while manual reset input is low.
// - After manual reset rises, reset stays asserted for full reset delay.
// - Reset asserts at once when supply is below the falling threshold.
// - Supply back in range starts reset delay; release only when it completes.
// - From power-on, reset holds until supply good and delay count finished.
// - Watchdog disabled entirely while timeout select is low.
// - Timeout from select plus config: capacitor, pulled-up or open preset.
// - Host kicks with falling edges before timeout; each edge restarts count.
// - Kick ignored while reset asserted, watchdog output asserted or disabled.
// - Watchdog output asserts when count expires without a kick edge.
// - Watchdog output may assert only while reset output is released.
// - Watchdog output holds exactly the reset delay, then releases.
// - While reset is asserted the watchdog output is released.
// - Standard capacitor timeout spans about 0.704 ms to 3.23 s.
// - Extended capacitor timeout spans about 62.74 ms to 77.45 s.
// - Reset asserts while supply is below the lockout level.
`timescale 1ns/10ps
`include "svw_params.svh"

module svw_top #(
    parameter int unsigned RST_CYCLES      = `SVW_MS_CYCLES(`SVW_T_RST_MS),
    parameter int unsigned WD_OPEN_CYCLES  = `SVW_MS_CYCLES(`SVW_T_WD_OPEN_MS),
    parameter int unsigned WD_PULLUP_CYCLES = `SVW_MS_CYCLES(`SVW_T_WD_PULLUP_MS),
    parameter bit          EXTENDED_TIMING = 1'b0
) (
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    input  wire svw_pkg::svw_supply_type supply_i,
    input  wire logic                    manual_reset_n_i,
    input  wire logic                    watchdog_kick_in_i,
    input  wire svw_pkg::svw_wd_cfg_type wd_cfg_i,
    output logic                         reset_n_o,
    output logic                         watchdog_timeout_n_o
);
    import svw_pkg::*;

    // ************************************************************
    // Timing limits
    // ************************************************************
    localparam logic [31:0] RST_LAST = 32'(RST_CYCLES - 1);
    localparam logic [31:0] CAP_MIN  = EXTENDED_TIMING ?
        32'(`SVW_US_CYCLES(`SVW_T_CAP_EXT_MIN_US)) :
        32'(`SVW_US_CYCLES(`SVW_T_CAP_STD_MIN_US));
    localparam logic [31:0] CAP_MAX  = EXTENDED_TIMING ?
        32'(`SVW_US_CYCLES(`SVW_T_CAP_EXT_MAX_US)) :
        32'(`SVW_US_CYCLES(`SVW_T_CAP_STD_MAX_US));

    // Last count of the watchdog window for a configuration
    function automatic logic [31:0] wd_last_f(input svw_wd_cfg_type cfg);
        logic [31:0] cyc;
        cyc = 32'(WD_OPEN_CYCLES);
        unique case (cfg.timeout_cfg_in)
            SVW_CFG_CAP: begin
                if (cfg.cap_cycles < CAP_MIN) begin
                    cyc = CAP_MIN;
                end else if (cfg.cap_cycles > CAP_MAX) begin
                    cyc = CAP_MAX;
                end else begin
                    cyc = cfg.cap_cycles;
                end
            end
            SVW_CFG_PULLUP: cyc = 32'(WD_PULLUP_CYCLES);
            SVW_CFG_OPEN:   cyc = 32'(WD_OPEN_CYCLES);
            default:        cyc = 32'(WD_OPEN_CYCLES);
        endcase
        return cyc - `SVW_CNT_ONE;
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    svw_state_type          state;
    svw_state_type          next_state;
    logic [`SVW_CNT_W-1:0]  cnt;
    logic [`SVW_CNT_W-1:0]  next_cnt;
    logic                   kick_prev;
    wire logic              hold_cond;
    wire logic              kick_fall;
    wire logic              wd_enabled;
    wire logic [31:0]       wd_last;
    wire logic              cnt_at_rst;
    wire logic              cnt_at_wd;

    // Reset sources and watchdog qualifiers
    assign hold_cond  = supply_i.lockout | supply_i.undervoltage
                      | ~manual_reset_n_i;
    assign kick_fall  = kick_prev & ~watchdog_kick_in_i;
    assign wd_enabled = wd_cfg_i.timeout_select;
    assign wd_last    = wd_last_f(wd_cfg_i);
    assign cnt_at_rst = (cnt == RST_LAST);
    assign cnt_at_wd  = (cnt >= wd_last);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt   = cnt + `SVW_CNT_ONE;
        if (hold_cond) begin
            next_state = SVW_ST_HOLD;
            next_cnt   = `SVW_CNT_ZERO;
        end else begin
            unique case (state)
                SVW_ST_HOLD: begin
                    if (!supply_i.supply_good) begin
                        next_cnt = `SVW_CNT_ZERO;
                    end else if (cnt_at_rst) begin
                        next_state = SVW_ST_RUN;
                        next_cnt   = `SVW_CNT_ZERO;
                    end
                end
                SVW_ST_RUN: begin
                    if (!wd_enabled || kick_fall) begin
                        next_cnt = `SVW_CNT_ZERO;
                    end else if (cnt_at_wd) begin
                        next_state = SVW_ST_WDO;
                        next_cnt   = `SVW_CNT_ZERO;
                    end
                end
                SVW_ST_WDO: begin
                    // Kick edges have no effect here
                    if (!wd_enabled || cnt_at_rst) begin
                        next_state = SVW_ST_RUN;
                        next_cnt   = `SVW_CNT_ZERO;
                    end
                end
                default: begin
                    next_state = SVW_ST_HOLD;
                    next_cnt   = `SVW_CNT_ZERO;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state     <= SVW_ST_HOLD;
            cnt       <= `SVW_CNT_ZERO;
            kick_prev <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            kick_prev <= watchdog_kick_in_i;
        end
    end

    // Outputs straight from flops; watchdog released in hold
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_n_o            <= 1'b0;
            watchdog_timeout_n_o <= 1'b1;
        end else begin
            reset_n_o            <= (next_state != SVW_ST_HOLD);
            watchdog_timeout_n_o <= (next_state != SVW_ST_WDO);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [31:0] rel_run;
    logic [31:0] wdo_run;

    // Clean cycles before release, and length of watchdog pulse
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rel_run <= `SVW_CNT_ZERO;
            wdo_run <= `SVW_CNT_ZERO;
        end else begin
            rel_run <= (hold_cond || !supply_i.supply_good || reset_n_o) ?
                       `SVW_CNT_ZERO : rel_run + `SVW_CNT_ONE;
            wdo_run <= watchdog_timeout_n_o ? `SVW_CNT_ZERO : wdo_run + `SVW_CNT_ONE;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_mr_asserts;
        !manual_reset_n_i |=> !reset_n_o;
    endproperty
    a_mr_asserts: assert property (p_mr_asserts)
        else $error("reset not asserted by manual reset");

    property p_uv_asserts;
        supply_i.undervoltage |=> !reset_n_o;
    endproperty
    a_uv_asserts: assert property (p_uv_asserts)
        else $error("reset not asserted on undervoltage");

    property p_lockout;
        supply_i.lockout |=> !reset_n_o;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("reset not asserted on lockout");

    property p_release_delay;
        $rose(reset_n_o) |-> (rel_run == 32'(RST_CYCLES));
    endproperty
    a_release_delay: assert property (p_release_delay)
        else $error("reset released without full delay");

    property p_disabled;
        !wd_cfg_i.timeout_select |=> watchdog_timeout_n_o;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("watchdog output asserted while disabled");

    property p_wdo_needs_reset_high;
        !watchdog_timeout_n_o |-> reset_n_o;
    endproperty
    a_wdo_needs_reset_high: assert property (p_wdo_needs_reset_high)
        else $error("watchdog output asserted during reset");

    property p_wdo_length;
        $rose(watchdog_timeout_n_o) && reset_n_o && $past(wd_cfg_i.timeout_select)
            |-> ($past(wdo_run) == 32'(RST_CYCLES - 1));
    endproperty
    a_wdo_length: assert property (p_wdo_length)
        else $error("watchdog pulse length wrong");

    property p_expire;
        $fell(watchdog_timeout_n_o) |-> ($past(cnt) >= $past(wd_last));
    endproperty
    a_expire: assert property (p_expire)
        else $error("watchdog output asserted before expiry");

    property p_kick_restart;
        (state == SVW_ST_RUN) && kick_fall && !hold_cond |=> (cnt == `SVW_CNT_ZERO);
    endproperty
    a_kick_restart: assert property (p_kick_restart)
        else $error("kick edge did not restart count");

endmodule // svw_top

// >>> verif/svw_host.sv
// Host processor model that kicks the watchdog
`timescale 1ns/10ps
module svw_host #(
    parameter int HALF = 10
) (
    input  wire logic mclk_i,
    input  wire logic kick_en_i,
    output logic      kick_o
);
    int   cnt      = 0;
    logic kick_lvl = 1'b1;
    // Idle level is always a defined high or low
    assign kick_o = kick_lvl;
    // Square wave; one falling edge every two half periods
    always @(posedge mclk_i) begin
        if (kick_en_i) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                kick_lvl <= ~kick_lvl;
            end
        end
    end
endmodule // svw_host

// >>> verif/svw_top_tb.sv
// Self-checking bench for the supervisor watchdog
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module svw_top_tb;
    import svw_pkg::*;
    localparam int RST = 20;
    logic           mclk_i, reset_n_i, manual_reset_n, kick, kick_en;
    logic           kick_q = 1'b1;
    logic           rst_n, wdo_n;
    svw_supply_type sup;
    svw_wd_cfg_type cfg;
    int             n_errors = 0, n_checks = 0, cyc = 0, last_fall = 0;
    svw_cfg_src_type srcs[5] = '{SVW_CFG_PULLUP, SVW_CFG_OPEN, svw_cfg_src_type'(2'b11),
                                 SVW_CFG_CAP, SVW_CFG_CAP};
    int             tmo[5] = '{30, 50, 50, 14080, 15000};

    svw_top #(.RST_CYCLES(RST), .WD_OPEN_CYCLES(50), .WD_PULLUP_CYCLES(30),
              .EXTENDED_TIMING(1'b0)) svw_top_inst (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .supply_i(sup),
        .manual_reset_n_i(manual_reset_n), .watchdog_kick_in_i(kick), .wd_cfg_i(cfg),
        .reset_n_o(rst_n), .watchdog_timeout_n_o(wdo_n));
    svw_host #(.HALF(10)) svw_host_inst (.mclk_i(mclk_i), .kick_en_i(kick_en), .kick_o(kick));

    // 20 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    // Cycle count and time of the last kick edge
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        kick_q <= kick;
        if (kick_q && !kick) last_fall <= cyc;
    end

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Cycles from hold removal to reset release
    task automatic rel_check();
        int d;
        d = 0;
        while (rst_n !== 1'b1 && d < 200) begin
            @(negedge mclk_i);
            d++;
        end
        `CHK(d >= RST - 1 && d <= RST + 2, 1'b1)
    endtask
    // Stop kicking, time the expiry and the pulse, optionally kick in the pulse
    task automatic wd_check(int t, bit resume);
        int d;
        @(posedge mclk_i);
        kick_en <= 1'b0;
        d = 0;
        while (wdo_n !== 1'b0 && d < t + 100) begin
            @(negedge mclk_i);
            d++;
        end
        d = cyc - last_fall;
        `CHK(d >= t - 2 && d <= t + 4, 1'b1)
        @(posedge mclk_i);
        kick_en <= resume;
        d = 1;
        while (wdo_n !== 1'b1 && d < 200) begin
            @(negedge mclk_i);
            d++;
            `CHK(rst_n, 1'b1)
        end
        `CHK(d >= RST - 1 && d <= RST + 2, 1'b1)
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (60000) @(posedge mclk_i);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        reset_n_i = 1'b0;
        manual_reset_n = 1'b1;
        kick_en = 1'b0;
        sup = '0;
        cfg = '0;
        cfg.timeout_cfg_in = SVW_CFG_PULLUP;
        repeat (10) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (40) @(negedge mclk_i);
        `CHK(rst_n, 1'b0)
        `CHK(wdo_n, 1'b1)
        @(posedge mclk_i);
        sup.supply_good <= 1'b1;
        rel_check();
        // Manual, undervoltage and lockout holds
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            manual_reset_n <= (i != 0);
            sup.undervoltage <= (i == 1);
            sup.lockout <= (i == 2);
            repeat (3) @(negedge mclk_i);
            `CHK(rst_n, 1'b0)
            `CHK(wdo_n, 1'b1)
            @(posedge mclk_i);
            manual_reset_n <= 1'b1;
            sup.undervoltage <= 1'b0;
            sup.lockout <= 1'b0;
            rel_check();
        end
        // Disabled watchdog, then enabled and kicked watchdog, never fires
        repeat (200) begin
            @(negedge mclk_i);
            `CHK(wdo_n, 1'b1)
        end
        @(posedge mclk_i);
        cfg.timeout_select <= 1'b1;
        kick_en <= 1'b1;
        repeat (200) begin
            @(negedge mclk_i);
            `CHK(wdo_n, 1'b1)
        end
        // Every timeout source, capacitor at its floor and in range
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            kick_en <= 1'b1;
            cfg.timeout_cfg_in <= srcs[i];
            cfg.cap_cycles <= (i == 4) ? 32'h0000_3a98 : 32'h0000_0000;
            repeat (60) @(posedge mclk_i);
            wd_check(tmo[i], i[0]);
        end
        wrap_up();
    end
endmodule // svw_top_tb
